// ---- hw/rnp_pkg.sv ----
// package for the radio network parameter bank: offsets, resets, ranges, types
package rnp_pkg;
  // register indices; the byte address is four times the index
  localparam logic [7:0] IX_BAND = 8'h00;
  localparam logic [7:0] IX_SLOTS = 8'h01;
  localparam logic [7:0] IX_BSIZE = 8'h02;
  localparam logic [7:0] IX_LEASE = 8'h03;
  localparam logic [7:0] IX_BCST = 8'h04;
  localparam logic [7:0] IX_ARQ = 8'h05;
  localparam logic [7:0] IX_DROP = 8'h06;
  localparam logic [7:0] IX_P2P = 8'h07;
  localparam logic [7:0] IX_REG = 8'h08;
  localparam logic [7:0] IX_NBP = 8'h09;
  localparam logic [7:0] IX_DEST = 8'h0a;
  localparam logic [7:0] IX_RELAY = 8'h0b;
  localparam logic [7:0] IX_NETID = 8'h0c;
  localparam logic [7:0] IX_HB = 8'h0d;
  localparam logic [7:0] IX_SYSID = 8'h0e;
  localparam logic [7:0] IX_ACK = 8'h0f;
  localparam logic [7:0] IX_RELINK = 8'h10;
  localparam logic [7:0] IX_FBC = 8'h11;
  localparam logic [7:0] IX_FBT = 8'h12;
  localparam logic [7:0] IX_MODE = 8'h13;
  localparam logic [7:0] IX_CMD = 8'h14;
  localparam logic [7:0] IX_STAT = 8'h15;
  localparam logic [7:0] IX_EVENT = 8'h16;
  localparam logic [7:0] IX_LAST = 8'h16;
  // reset values
  localparam logic [7:0] RST_BAND = 8'h00;
  localparam logic [7:0] RST_SLOTS = 8'h03;
  localparam logic [7:0] RST_BSIZE = 8'h28;
  localparam logic [7:0] RST_LEASE = 8'h02;
  localparam logic [7:0] RST_BCST = 8'h01;
  localparam logic [7:0] RST_ARQ = 8'h06;
  localparam logic [7:0] RST_DROP = 8'h0a;
  localparam logic [7:0] RST_P2P = 8'h64;
  localparam logic [7:0] RST_REG = 8'h32;
  localparam logic [7:0] RST_NBP = 8'h15;
  localparam logic [23:0] RST_DEST = 24'h000000;
  localparam logic [23:0] DEST_BCAST = 24'hffffff;
  localparam logic [7:0] RST_NETID = 8'hff;
  localparam logic [15:0] RST_HB = 16'hffff;
  // ranges
  localparam logic [7:0] NETID_MAX = 8'h3f;
  localparam logic [7:0] BAND_MAX = 8'h0d;
  localparam logic [7:0] BAND_AUTO = 8'hff;
  localparam logic [7:0] BAND_FAST = 8'h0c;
  localparam logic [7:0] SLOTS_MAX = 8'h08;
  localparam logic [7:0] BSIZE_MIN = 8'h06;
  localparam logic [7:0] BSIZE_MAX = 8'h69;
  localparam logic [7:0] BCST_MAX = 8'hfe;
  localparam logic [7:0] ARQ_INF = 8'hff;
  localparam logic [7:0] NBP_MIN = 8'h08;
  localparam logic [7:0] NBP_MAX = 8'h15;
  // device modes
  localparam logic [1:0] MODE_REMOTE = 2'h0;
  localparam logic [1:0] MODE_BASE = 2'h1;
  localparam logic [1:0] MODE_ROUTER = 2'h2;
  // command register bits
  localparam int CMD_SAVE = 0;
  localparam int CMD_BEACON = 1;
  localparam int CMD_SECOND = 2;
  localparam int CMD_HOP = 3;
  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int FAST_HOP_US = 6000;
  localparam int FAST_HOP_CYC = CLK_HZ / 1_000_000 * FAST_HOP_US;
  localparam int SEC_CYC_DEF = CLK_HZ;
  // band classes
  localparam logic [1:0] BC_24 = 2'h0;
  localparam logic [1:0] BC_15 = 2'h1;
  localparam logic [1:0] BC_5 = 2'h2;
  localparam logic [1:0] BC_AUTO = 2'h3;

  // stored parameter set
  typedef struct packed {
    logic [7:0] band;
    logic [7:0] slots;
    logic [7:0] bsize;
    logic [7:0] lease;
    logic [7:0] bcst;
    logic [7:0] arq;
    logic [7:0] drop;
    logic [7:0] p2p;
    logic [7:0] regto;
    logic [7:0] nbp;
    logic [23:0] dest;
    logic relay;
    logic [7:0] netid;
    logic [15:0] hb;
    logic [7:0] sysid;
    logic ack;
    logic [15:0] relink;
    logic [15:0] fbc;
    logic [7:0] fbt;
  } rnp_par_t;

  // radio events from the node logic (one-cycle pulses)
  typedef struct packed {
    logic linkup;
    logic beacon_miss;
    logic beacon_seen;
    logic child_msg;
    logic reply_rx;
    logic tx_start;
    logic sleep_pend;
  } rnp_evt_t;
endpackage : rnp_pkg

// ---- hw/rnp_bank.sv ----
// radio network parameter bank with APB slave and timing engines
//
// The APB register port was decided locally.
module rnp_bank #(
  parameter int SEC_CYC = rnp_pkg::SEC_CYC_DEF
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // node events from the radio core
  input wire rnp_pkg::rnp_evt_t EVT,
  // derived controls to the radio core
  output logic [23:0] TX_DEST,
  output logic ACK_REQ,
  output logic HB_SEND,
  output logic RELINK,
  output logic WAKE,
  output logic BEACON,
  output logic FAST_MODE,
  output logic [7:0] EFF_BSIZE,
  output logic [7:0] EFF_SLOTS,
  output logic [7:0] TX_ATTEMPTS,
  output logic TX_UNLIMITED,
  output logic [7:0] BCST_REPEATS,
  output logic SLOT_HELD,
  output logic HIST_VALID,
  output logic REPLY_OK,
  output logic REPLY_FAIL,
  output logic [1:0] BAND_CLASS,
  output logic ACT_REMOTE
);

  typedef enum logic [2:0] {
    ST_INIT = 3'b001,
    ST_RUN = 3'b010,
    ST_FAST = 3'b100
  } rnp_st_t;

  typedef struct packed {
    rnp_st_t st;
    rnp_pkg::rnp_par_t par;
    rnp_pkg::rnp_par_t saved;
    logic [1:0] mode;
    logic [31:0] sec_cnt;
    logic [31:0] hop_cnt;
    logic [15:0] hb_cnt;
    logic [15:0] relink_cnt;
    logic relink_arm;
    logic [15:0] fast_left;
    logic [7:0] miss_cnt;
    logic [7:0] lease_cnt;
    logic [7:0] reg_cnt;
    logic [8:0] reply_cnt;
    logic reply_wait;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [23:0] tx_dest;
    logic hb_send;
    logic relink;
    logic wake;
    logic beacon;
    logic reply_ok;
    logic reply_fail;
  } rnp_state_t;

  rnp_state_t s_r;
  rnp_state_t s_nxt;

  // range check per register, shared by write path
  function automatic logic in_range(input logic [7:0] ix, input logic [15:0] v);
    logic ok;
    ok = 1'b1;
    case (ix)
      rnp_pkg::IX_BAND: ok = (v[7:0] <= rnp_pkg::BAND_MAX) || (v[7:0] == rnp_pkg::BAND_AUTO);
      rnp_pkg::IX_SLOTS: ok = (v[7:0] != 8'h00) && (v[7:0] <= rnp_pkg::SLOTS_MAX);
      rnp_pkg::IX_BSIZE: ok = (v[7:0] >= rnp_pkg::BSIZE_MIN) && (v[7:0] <= rnp_pkg::BSIZE_MAX);
      rnp_pkg::IX_LEASE: ok = (v[7:0] != 8'h00);
      rnp_pkg::IX_BCST: ok = (v[7:0] <= rnp_pkg::BCST_MAX);
      rnp_pkg::IX_ARQ: ok = (v[7:0] != 8'h00);
      rnp_pkg::IX_DROP: ok = (v[7:0] != 8'h00);
      rnp_pkg::IX_NBP: ok = (v[7:0] >= rnp_pkg::NBP_MIN) && (v[7:0] <= rnp_pkg::NBP_MAX);
      rnp_pkg::IX_RELAY: ok = (v[7:1] == 7'h00);
      rnp_pkg::IX_ACK: ok = (v[7:1] == 7'h00);
      default: ok = 1'b1;
    endcase
    return ok;
  endfunction : in_range

  // reset image of the parameter set
  function automatic rnp_pkg::rnp_par_t par_default();
    rnp_pkg::rnp_par_t p;
    p = '0;
    p.band = rnp_pkg::RST_BAND;
    p.slots = rnp_pkg::RST_SLOTS;
    p.bsize = rnp_pkg::RST_BSIZE;
    p.lease = rnp_pkg::RST_LEASE;
    p.bcst = rnp_pkg::RST_BCST;
    p.arq = rnp_pkg::RST_ARQ;
    p.drop = rnp_pkg::RST_DROP;
    p.p2p = rnp_pkg::RST_P2P;
    p.regto = rnp_pkg::RST_REG;
    p.nbp = rnp_pkg::RST_NBP;
    p.dest = rnp_pkg::RST_DEST;
    p.netid = rnp_pkg::RST_NETID;
    p.hb = rnp_pkg::RST_HB;
    return p;
  endfunction : par_default

  logic is_base;
  logic netid_ok;
  logic sys_ix;
  logic acc;
  logic wr;
  logic sec_tick;
  logic hop_tick;
  logic [31:0] hop_len;
  logic [31:0] rd;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_nxt = s_r;
    is_base = (s_r.mode == rnp_pkg::MODE_BASE);
    netid_ok = (s_r.par.netid <= rnp_pkg::NETID_MAX);
    sys_ix = (PADDR[7:2] <= rnp_pkg::IX_NBP[5:0]) && (PADDR[7:2] != rnp_pkg::IX_BAND[5:0]);
    acc = PSEL && PENABLE;
    wr = acc && PWRITE;
    hop_len = (s_r.st == ST_FAST) ? 32'(rnp_pkg::FAST_HOP_CYC) : 32'(SEC_CYC);
    s_nxt.hb_send = 1'b0;
    s_nxt.relink = 1'b0;
    s_nxt.wake = 1'b0;
    s_nxt.beacon = 1'b0;
    s_nxt.reply_ok = 1'b0;
    s_nxt.reply_fail = 1'b0;
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    // one-second divider; counts as a slow enable pulse
    sec_tick = (s_r.sec_cnt == 32'(SEC_CYC - 1));
    s_nxt.sec_cnt = sec_tick ? 32'h0 : s_r.sec_cnt + 32'h1;
    // burst hop divider, only active in burst mode
    hop_tick = (s_r.st == ST_FAST) && (s_r.hop_cnt >= hop_len - 32'h1);
    s_nxt.hop_cnt = (hop_tick || s_r.st != ST_FAST) ? 32'h0 : s_r.hop_cnt + 32'h1;

    case (s_r.st)
      ST_INIT: begin
        // startup fixups once the strapped mode is held
        if (is_base && s_r.par.dest == rnp_pkg::RST_DEST) begin
          s_nxt.par.dest = rnp_pkg::DEST_BCAST;
        end
        if (is_base && !netid_ok) begin
          s_nxt.par.netid = 8'h00;
        end
        s_nxt.st = (is_base && s_r.par.fbc != 16'h0000) ? ST_FAST : ST_RUN;
        s_nxt.fast_left = s_r.par.fbc;
      end
      ST_RUN: begin
        if (is_base && s_r.par.fbt != 8'h00) begin
          s_nxt.par.fbt = 8'h00;
          if (s_r.par.fbc != 16'h0000) begin
            s_nxt.st = ST_FAST;
            s_nxt.fast_left = s_r.par.fbc;
          end
        end
      end
      ST_FAST: begin
        // each 6 ms beacon takes one from the shared count
        if (hop_tick) begin
          s_nxt.beacon = is_base;
          s_nxt.fast_left = s_r.fast_left - 16'h1;
          if (s_r.fast_left == 16'h0001) begin
            s_nxt.st = ST_RUN;
          end
        end
        if (is_base && s_r.par.fbt != 8'h00) begin
          s_nxt.par.fbt = 8'h00;
        end
      end
      default: s_nxt.st = ST_INIT;
    endcase

    // heartbeats: zero none, all ones linkup only, else periodic
    if (EVT.linkup && s_r.par.hb != 16'h0000) begin
      s_nxt.hb_send = 1'b1;
      s_nxt.hb_cnt = 16'h0;
    end else if (sec_tick && s_r.par.hb != 16'h0000 && s_r.par.hb != rnp_pkg::RST_HB) begin
      s_nxt.hb_cnt = s_r.hb_cnt + 16'h1;
      if (s_r.hb_cnt + 16'h1 >= s_r.par.hb) begin
        s_nxt.hb_send = 1'b1;
        s_nxt.hb_cnt = 16'h0;
      end
    end

    // sleep relink timer, armed by sleep with pending queue
    if (EVT.sleep_pend && s_r.par.relink != 16'h0000) begin
      s_nxt.relink_arm = 1'b1;
      s_nxt.relink_cnt = 16'h0;
    end else if (s_r.relink_arm && sec_tick) begin
      s_nxt.relink_cnt = s_r.relink_cnt + 16'h1;
      if (s_r.relink_cnt + 16'h1 >= s_r.par.relink) begin
        s_nxt.wake = 1'b1;
        s_nxt.relink_arm = 1'b0;
      end
    end

    // missed beacon counter for remotes
    if (EVT.beacon_seen) begin
      s_nxt.miss_cnt = 8'h00;
    end else if (EVT.beacon_miss && !is_base) begin
      s_nxt.miss_cnt = s_r.miss_cnt + 8'h1;
      if (s_r.miss_cnt + 8'h1 >= s_r.par.drop) begin
        s_nxt.relink = 1'b1;
        s_nxt.miss_cnt = 8'h00;
      end
    end

    // slot lease and child history timers count hops without contact
    if (EVT.child_msg) begin
      s_nxt.lease_cnt = s_r.par.lease;
      s_nxt.reg_cnt = s_r.par.regto;
    end else if (EVT.beacon_seen || s_nxt.beacon) begin
      if (s_r.lease_cnt != 8'h00) s_nxt.lease_cnt = s_r.lease_cnt - 8'h1;
      if (s_r.reg_cnt != 8'h00) s_nxt.reg_cnt = s_r.reg_cnt - 8'h1;
    end

    // peer reply timeout; hop pairs when relaying, late replies dropped
    if (EVT.tx_start && s_r.par.ack) begin
      s_nxt.reply_wait = 1'b1;
      s_nxt.reply_cnt = s_r.par.relay ? {s_r.par.p2p, 1'b0} : {1'b0, s_r.par.p2p};
    end else if (s_r.reply_wait) begin
      if (EVT.reply_rx) begin
        s_nxt.reply_ok = 1'b1;
        s_nxt.reply_wait = 1'b0;
      end else if (s_r.reply_cnt == 9'h000) begin
        s_nxt.reply_fail = 1'b1;
        s_nxt.reply_wait = 1'b0;
      end else if (EVT.beacon_seen) begin
        s_nxt.reply_cnt = s_r.reply_cnt - 9'h1;
      end
    end

    // register read mux
    rd = 32'h0;
    case (PADDR[7:2])
      rnp_pkg::IX_BAND[5:0]: rd = {24'h0, s_r.par.band};
      rnp_pkg::IX_SLOTS[5:0]: rd = {24'h0, s_r.par.slots};
      rnp_pkg::IX_BSIZE[5:0]: rd = {24'h0, s_r.par.bsize};
      rnp_pkg::IX_LEASE[5:0]: rd = {24'h0, s_r.par.lease};
      rnp_pkg::IX_BCST[5:0]: rd = {24'h0, s_r.par.bcst};
      rnp_pkg::IX_ARQ[5:0]: rd = {24'h0, s_r.par.arq};
      rnp_pkg::IX_DROP[5:0]: rd = {24'h0, s_r.par.drop};
      rnp_pkg::IX_P2P[5:0]: rd = {24'h0, s_r.par.p2p};
      rnp_pkg::IX_REG[5:0]: rd = {24'h0, s_r.par.regto};
      rnp_pkg::IX_NBP[5:0]: rd = {24'h0, s_r.par.nbp};
      rnp_pkg::IX_DEST[5:0]: rd = {8'h0, s_r.par.dest};
      rnp_pkg::IX_RELAY[5:0]: rd = {31'h0, s_r.par.relay};
      rnp_pkg::IX_NETID[5:0]: rd = {24'h0, s_r.par.netid};
      rnp_pkg::IX_HB[5:0]: rd = {16'h0, s_r.par.hb};
      rnp_pkg::IX_SYSID[5:0]: rd = {24'h0, s_r.par.sysid};
      rnp_pkg::IX_ACK[5:0]: rd = {31'h0, s_r.par.ack};
      rnp_pkg::IX_RELINK[5:0]: rd = {16'h0, s_r.par.relink};
      rnp_pkg::IX_FBC[5:0]: rd = {16'h0, s_r.par.fbc};
      rnp_pkg::IX_FBT[5:0]: rd = {24'h0, s_r.par.fbt};
      rnp_pkg::IX_MODE[5:0]: rd = {30'h0, s_r.mode};
      rnp_pkg::IX_STAT[5:0]: rd = {13'h0, s_r.st, s_r.fast_left};
      rnp_pkg::IX_EVENT[5:0]: rd = {16'h0, s_r.miss_cnt, s_r.lease_cnt};
      default: rd = 32'h0;
    endcase

    // apb access phase: one wait state, answer in the following cycle
    if (acc && !s_r.pready) begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = rd;
      if (PADDR[7:2] > rnp_pkg::IX_LAST[5:0] || PADDR[1:0] != 2'b00) begin
        s_nxt.pslverr = 1'b1;
      end else if (wr) begin
        if (!in_range({2'b00, PADDR[7:2]}, PWDATA[15:0]) || PWDATA[31:24] != 8'h00 ||
            (PWDATA[23:16] != 8'h00 && PADDR[7:2] != rnp_pkg::IX_DEST[5:0])) begin
          s_nxt.pslverr = 1'b1;
        end else if (sys_ix && !is_base) begin
          s_nxt.pslverr = 1'b1;
        end else begin
          case (PADDR[7:2])
            rnp_pkg::IX_BAND[5:0]: s_nxt.par.band = PWDATA[7:0];
            rnp_pkg::IX_SLOTS[5:0]: s_nxt.par.slots = PWDATA[7:0];
            rnp_pkg::IX_BSIZE[5:0]: s_nxt.par.bsize = PWDATA[7:0];
            rnp_pkg::IX_LEASE[5:0]: s_nxt.par.lease = PWDATA[7:0];
            rnp_pkg::IX_BCST[5:0]: s_nxt.par.bcst = PWDATA[7:0];
            rnp_pkg::IX_ARQ[5:0]: s_nxt.par.arq = PWDATA[7:0];
            rnp_pkg::IX_DROP[5:0]: s_nxt.par.drop = PWDATA[7:0];
            rnp_pkg::IX_P2P[5:0]: s_nxt.par.p2p = PWDATA[7:0];
            rnp_pkg::IX_REG[5:0]: s_nxt.par.regto = PWDATA[7:0];
            rnp_pkg::IX_NBP[5:0]: s_nxt.par.nbp = PWDATA[7:0];
            rnp_pkg::IX_DEST[5:0]: s_nxt.par.dest = PWDATA[23:0];
            rnp_pkg::IX_RELAY[5:0]: s_nxt.par.relay = PWDATA[0];
            // base clamps invalid id, others keep it and a router falls back
            rnp_pkg::IX_NETID[5:0]: s_nxt.par.netid =
              (is_base && PWDATA[7:0] > rnp_pkg::NETID_MAX) ? 8'h00 : PWDATA[7:0];
            rnp_pkg::IX_HB[5:0]: s_nxt.par.hb = PWDATA[15:0];
            rnp_pkg::IX_SYSID[5:0]: s_nxt.par.sysid = PWDATA[7:0];
            rnp_pkg::IX_ACK[5:0]: s_nxt.par.ack = PWDATA[0];
            rnp_pkg::IX_RELINK[5:0]: s_nxt.par.relink = PWDATA[15:0];
            rnp_pkg::IX_FBC[5:0]: s_nxt.par.fbc = PWDATA[15:0];
            rnp_pkg::IX_FBT[5:0]: s_nxt.par.fbt = PWDATA[7:0];
            // mode writes are accepted but change nothing; mode keeps its reset value
            rnp_pkg::IX_MODE[5:0]: s_nxt.saved.netid = s_r.saved.netid;
            rnp_pkg::IX_CMD[5:0]: begin
              if (PWDATA[rnp_pkg::CMD_SAVE]) s_nxt.saved = s_r.par;
            end
            default: s_nxt.pslverr = 1'b1;
          endcase
        end
      end
    end

    // outputs derived from the live set
    s_nxt.tx_dest = s_nxt.par.dest;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; the saved image stands in for nonvolatile storage
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      s_r <= '0;
      s_r.st <= ST_INIT;
      s_r.par <= par_default();
      s_r.saved <= par_default();
      s_r.mode <= rnp_pkg::MODE_REMOTE;
      s_r.tx_dest <= rnp_pkg::RST_DEST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output assignments, all straight from the state register
  assign PRDATA = s_r.prdata;
  assign PREADY = s_r.pready;
  assign PSLVERR = s_r.pslverr;
  assign TX_DEST = s_r.tx_dest;
  assign ACK_REQ = s_r.par.ack;
  assign HB_SEND = s_r.hb_send;
  assign RELINK = s_r.relink;
  assign WAKE = s_r.wake;
  assign BEACON = s_r.beacon;
  assign FAST_MODE = s_r.st[2];
  assign EFF_BSIZE = s_r.st[2] ? 8'h00 : s_r.par.bsize;
  assign EFF_SLOTS = s_r.st[2] ? 8'h01 : s_r.par.slots;
  assign TX_ATTEMPTS = s_r.par.arq;
  assign TX_UNLIMITED = (s_r.par.arq == rnp_pkg::ARQ_INF);
  assign BCST_REPEATS = (s_r.par.bcst == 8'h00) ? s_r.par.arq : s_r.par.bcst;
  assign SLOT_HELD = (s_r.lease_cnt != 8'h00);
  assign HIST_VALID = (s_r.reg_cnt != 8'h00);
  assign REPLY_OK = s_r.reply_ok;
  assign REPLY_FAIL = s_r.reply_fail;
  assign BAND_CLASS = (s_r.par.band == rnp_pkg::BAND_AUTO) ? rnp_pkg::BC_AUTO :
    (s_r.par.band >= rnp_pkg::BAND_FAST) ? rnp_pkg::BC_5 :
    (s_r.par.band == 8'h00) ? rnp_pkg::BC_24 : rnp_pkg::BC_15;
  assign ACT_REMOTE = (s_r.mode == rnp_pkg::MODE_REMOTE) ||
    ((s_r.mode == rnp_pkg::MODE_ROUTER) && (s_r.par.netid > rnp_pkg::NETID_MAX));

endmodule : rnp_bank

// ---- testbench/rnp_bank_properties.sv ----
// port checker for the radio network parameter bank
module rnp_bank_chk #(
  parameter int SEC_CYC = 100
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // derived controls
  input wire logic [23:0] TX_DEST,
  input wire logic ACK_REQ,
  input wire logic BEACON,
  input wire logic FAST_MODE,
  input wire logic [7:0] EFF_BSIZE,
  input wire logic [7:0] EFF_SLOTS,
  input wire logic [7:0] TX_ATTEMPTS,
  input wire logic TX_UNLIMITED,
  input wire logic REPLY_OK,
  input wire logic REPLY_FAIL,
  input wire logic ACT_REMOTE
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!NRST);
  ////////////////////////////////////////////////////////////////////////////////
  // bus answer: one wait state, answer stands one cycle
  a_ready_once: assert property (PREADY |=> !PREADY) else $error("ready held too long");
  a_ready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY) else $error("ready late");
  a_err_ready: assert property (PSLVERR |-> PREADY) else $error("error without ready");
  // burst mode forces the short slot layout
  a_fast_slots: assert property (FAST_MODE |-> EFF_BSIZE == 8'h00 && EFF_SLOTS == 8'h01)
    else $error("burst slot layout wrong");
  a_unlim_flag: assert property (TX_UNLIMITED == (TX_ATTEMPTS == 8'hff))
    else $error("unlimited flag wrong");
  a_remote_quiet: assert property (ACT_REMOTE |-> !BEACON) else $error("child beacon");
  a_reply_single: assert property (!(REPLY_OK && REPLY_FAIL)) else $error("both replies");
  // controls move only on a bus write
  a_dest_hold: assert property (!(PSEL && PENABLE && PWRITE) |=> $stable(TX_DEST))
    else $error("destination moved");
  a_ack_hold: assert property (!(PSEL && PENABLE && PWRITE) |=> $stable(ACK_REQ))
    else $error("ack flag moved");
endmodule : rnp_bank_chk

bind rnp_bank rnp_bank_chk #(.SEC_CYC(SEC_CYC)) rnp_bank_chk_i (.CORE_CLK, .NRST, .PSEL,
  .PENABLE, .PWRITE, .PREADY, .PSLVERR, .TX_DEST, .ACK_REQ, .BEACON, .FAST_MODE, .EFF_BSIZE,
  .EFF_SLOTS, .TX_ATTEMPTS, .TX_UNLIMITED, .REPLY_OK, .REPLY_FAIL, .ACT_REMOTE);

// ---- testbench/rnp_radio_model.sv ----
// behavioural radio core: trains of event pulses into the bank
module rnp_radio_model (
  // clock
  input wire logic clk,
  // request from the bench
  input wire rnp_pkg::rnp_evt_t kind,
  input wire logic [7:0] count,
  input wire logic start,
  // events to the bank
  output rnp_pkg::rnp_evt_t evt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left = 8'h00;
  logic gap = 1'b0;
  initial evt = '0;
  // one pulse every other cycle, so hops never merge into one
  always @(posedge clk) begin
    evt <= (!start && left != 8'h00 && !gap) ? kind : '0;
    gap <= start ? 1'b0 : (left != 8'h00) ? !gap : gap;
    left <= start ? count : (left != 8'h00 && !gap) ? left - 8'h01 : left;
  end
endmodule : rnp_radio_model

// ---- testbench/rnp_bank_test.sv ----
// self-checking bench for the radio network parameter bank
module rnp_bank_test;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
  localparam rnp_pkg::rnp_evt_t E_LINK = 7'h40, E_MISS = 7'h20, E_SEEN = 7'h10;
  localparam rnp_pkg::rnp_evt_t E_RPLY = 7'h04, E_TX = 7'h02, E_SLP = 7'h01, E_CHLD = 7'h08;
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, start = 1'b0;
  logic [7:0] paddr = 8'h00, count = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic err, pready, pslverr, ack_req, hb_send, relink, wake, beacon, fast_mode, tx_unl;
  logic reply_ok, reply_fail, act_remote, slot_held, hist_valid;
  logic [23:0] tx_dest;
  logic [7:0] eff_bsize, eff_slots, tx_attempts, bcst_rep;
  logic [1:0] band_class;
  rnp_pkg::rnp_evt_t evt, kind = '0;
  int fail_count = 0, cmp_count = 0, hb_n = 0, rl_n = 0, wk_n = 0, ok_n = 0, nak_n = 0, bc_n = 0;
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  // seconds shortened to 100 cycles to keep timer runs short
  rnp_bank #(.SEC_CYC(100)) rnp_bank_i (.CORE_CLK(clk), .NRST(nrst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .EVT(evt), .TX_DEST(tx_dest), .ACK_REQ(ack_req),
    .HB_SEND(hb_send), .RELINK(relink), .WAKE(wake), .BEACON(beacon), .FAST_MODE(fast_mode),
    .EFF_BSIZE(eff_bsize), .EFF_SLOTS(eff_slots), .TX_ATTEMPTS(tx_attempts),
    .TX_UNLIMITED(tx_unl), .BCST_REPEATS(bcst_rep), .SLOT_HELD(slot_held),
    .HIST_VALID(hist_valid),
    .REPLY_OK(reply_ok), .REPLY_FAIL(reply_fail), .BAND_CLASS(band_class),
    .ACT_REMOTE(act_remote));
  rnp_radio_model rnp_radio_model_i (.clk(clk), .kind(kind), .count(count), .start(start),
    .evt(evt));
  // pulse tallies; tests compare differences, never absolute counts
  always @(posedge clk) begin
    if (hb_send === 1'b1) hb_n++;
    if (relink === 1'b1) rl_n++;
    if (wake === 1'b1) wk_n++;
    if (reply_ok === 1'b1) ok_n++;
    if (reply_fail === 1'b1) nak_n++;
    if (beacon === 1'b1) bc_n++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one apb transfer; holds the request until ready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  // n event pulses from the radio model, then let the answers land
  task automatic fire(input rnp_pkg::rnp_evt_t k, input logic [7:0] n);
    kind <= k;
    count <= n;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (2 * n + 5) @(posedge clk);
  endtask : fire
  task automatic t_reset();
    logic [7:0] rv [10];
    rv = '{8'h00, 8'h03, 8'h28, 8'h02, 8'h01, 8'h06, 8'h0a, 8'h64, 8'h32, 8'h15};
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      `CHK(rd, {24'h0, rv[i]})
    end
    apb(1'b0, 8'h34, 32'h0);
    `CHK(rd, 32'hffff)
    `CHK(tx_dest, 24'h000000)
    `CHK(act_remote, 1'b1)
    `CHK({tx_unl, tx_attempts}, 9'h006)
    `CHK(bcst_rep, 8'h01)
    `CHK({fast_mode, eff_bsize, eff_slots}, 17'h02803)
  endtask : t_reset
  // system settings refused on a child, unmapped place refused
  task automatic t_refuse();
    apb(1'b1, 8'h04, 32'h5);
    `CHK(err, 1'b1)
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd, 32'h3)
    apb(1'b0, 8'h5c, 32'h0);
    `CHK(err, 1'b1)
  endtask : t_refuse
  task automatic t_band();
    logic [7:0] code [6];
    logic [1:0] cls [6];
    code = '{8'h00, 8'h01, 8'h0b, 8'h0c, 8'h0d, 8'hff};
    cls = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 8'h00, {24'h0, code[i]});
      `CHK({err, band_class}, {1'b0, cls[i]})
    end
    apb(1'b1, 8'h00, 32'h0e);
    apb(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'hff)
  endtask : t_band
  task automatic t_dest();
    apb(1'b1, 8'h28, 32'h123456);
    `CHK(tx_dest, 24'h123456)
    apb(1'b1, 8'h3c, 32'h1);
    `CHK(ack_req, 1'b1)
    apb(1'b1, 8'h3c, 32'h2);
    `CHK({err, ack_req}, 2'b11)
  endtask : t_dest
  task automatic t_heart();
    int h;
    apb(1'b1, 8'h34, 32'h0);
    h = hb_n;
    fire(E_LINK, 8'h1);
    `CHK(hb_n - h, 0)
    apb(1'b1, 8'h34, 32'hffff);
    fire(E_LINK, 8'h1);
    `CHK(hb_n - h, 1)
    // two-second period: 2 or 3 ticks fit the wait, either gives one beat
    apb(1'b1, 8'h34, 32'h2);
    repeat (250) @(posedge clk);
    `CHK(hb_n - h, 2)
  endtask : t_heart
  // nine misses are not enough, the tenth restarts the search
  task automatic t_drop();
    int r;
    r = rl_n;
    fire(E_MISS, 8'd9);
    `CHK(rl_n - r, 0)
    fire(E_MISS, 8'd1);
    `CHK(rl_n - r, 1)
  endtask : t_drop
  // two seconds of relink wait, then a zero period that never wakes
  task automatic t_wake();
    int w;
    apb(1'b1, 8'h40, 32'h2);
    w = wk_n;
    fire(E_SLP, 8'h1);
    repeat (90) @(posedge clk);
    `CHK(wk_n - w, 0)
    repeat (130) @(posedge clk);
    `CHK(wk_n - w, 1)
    apb(1'b1, 8'h40, 32'h0);
    fire(E_SLP, 8'h1);
    repeat (300) @(posedge clk);
    `CHK(wk_n - w, 1)
  endtask : t_wake
  task automatic t_trig();
    int b;
    b = bc_n;
    apb(1'b1, 8'h44, 32'h3);
    apb(1'b1, 8'h48, 32'h5);
    repeat (20) @(posedge clk);
    apb(1'b0, 8'h48, 32'h0);
    `CHK({rd[7:0], fast_mode}, 9'h0a)
    `CHK(bc_n - b, 0)
  endtask : t_trig
  // prompt reply, then a timeout at 100 hops and a late reply ignored
  task automatic t_reply();
    int k, f;
    k = ok_n;
    f = nak_n;
    fire(E_TX, 8'h1);
    fire(E_RPLY, 8'h1);
    `CHK(ok_n - k, 1)
    fire(E_TX, 8'h1);
    fire(E_SEEN, 8'd99);
    `CHK(nak_n - f, 0)
    fire(E_SEEN, 8'd2);
    `CHK(nak_n - f, 1)
    fire(E_RPLY, 8'h1);
    `CHK(ok_n - k, 1)
  endtask : t_reply
  // lease of 2 hops and history of 50 hops after one child message
  task automatic t_lease();
    fire(E_CHLD, 8'h1);
    fire(E_SEEN, 8'h1);
    `CHK({slot_held, hist_valid}, 2'b11)
    fire(E_SEEN, 8'h1);
    `CHK({slot_held, hist_valid}, 2'b01)
    fire(E_SEEN, 8'd47);
    `CHK(hist_valid, 1'b1)
    fire(E_SEEN, 8'h1);
    `CHK(hist_valid, 1'b0)
  endtask : t_lease
  // unsaved changes are lost across a reset in mid-run
  task automatic t_rerun();
    apb(1'b1, 8'h38, 32'h5a);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    apb(1'b0, 8'h38, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(tx_dest, 24'h000000)
  endtask : t_rerun
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_refuse();
    t_band();
    t_dest();
    t_heart();
    t_drop();
    t_wake();
    t_trig();
    t_reply();
    t_lease();
    t_rerun();
    stop_test();
  end
  // watchdog: the sequence needs about 1400 cycles
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test();
  end
endmodule : rnp_bank_test
